// *** hw/usr_shift_reg.sv ***
`timescale 1ns/1ps
// Function
// (R01) Four stages change only on rising clock edge, except during master clear.
// (R02) Parallel load enable low at edge loads the four parallel inputs. Code acts on pins synchronised two edges late, and not while stalled.
// (R03) Parallel load enable high at edge shifts right; first stage from J, K_n. Code acts on pins synchronised two edges late, and not while stalled.
// (R04) Outside logic ties J and K_n together for D-type serial entry.
// (R05) Active-low master clear empties all stages at once, overriding everything.
// (R06) Each stage has a true output; last stage also has an inverted output.
// (R07) First stage: J when holding 0, K_n when holding 1; others take predecessor.
module usr_shift_reg (
  input  wire logic                   clock_i,
  input  wire logic                   srst_i,
  input  wire logic                   master_clear_n_i,
  input  wire logic                   parallel_load_enable_n_i,
  input  wire logic [usr_pkg::STAGES-1:0] parallel_data_in_i,
  input  wire logic                   j_i,
  input  wire logic                   k_n_i,
  output logic      [usr_pkg::STAGES-1:0] stage_out_o,
  output logic                        last_stage_out_n_o,
  output logic                        step_stall_o,
  output logic      [usr_pkg::STAGES-1:0] snap_data_o,
  output logic                        snap_valid_o,
  input  wire logic                   snap_ready_i
);
  import usr_pkg::*;

  // Pin synchronisers; only stage two is read
  logic [1:0]        ple_sync_ff, nxt_ple_sync;
  logic [1:0]        j_sync_ff, nxt_j_sync;
  logic [1:0]        kn_sync_ff, nxt_kn_sync;
  logic [1:0]        clr_sync_ff, nxt_clr_sync;
  usr_word_t         pd_meta_ff, pd_sync_ff, nxt_pd_meta, nxt_pd_sync;
  usr_word_t         stage_ff, nxt_stage;
  logic              comp_ff, nxt_comp;
  logic              ple_s, j_s, kn_s, clr_idle_s, step;

  usr_stream_if #(.WIDTH(STAGES)) push_if ();
  usr_stream_if #(.WIDTH(STAGES)) pop_if ();

  assign ple_s      = ple_sync_ff[1];
  assign j_s        = j_sync_ff[1];
  assign kn_s       = kn_sync_ff[1];
  assign clr_idle_s = clr_sync_ff[1];

  always_comb begin
    nxt_ple_sync = {ple_sync_ff[0], parallel_load_enable_n_i};
    nxt_j_sync   = {j_sync_ff[0], j_i};
    nxt_kn_sync  = {kn_sync_ff[0], k_n_i};
    nxt_clr_sync = {clr_sync_ff[0], master_clear_n_i};
    nxt_pd_meta  = parallel_data_in_i;
    nxt_pd_sync  = pd_meta_ff;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ple_sync_ff <= SYNC_HI_RST;
      j_sync_ff   <= SYNC_RST;
      kn_sync_ff  <= SYNC_RST;
      clr_sync_ff <= SYNC_RST;
      pd_meta_ff  <= STAGE_RST;
      pd_sync_ff  <= STAGE_RST;
    end else begin
      ple_sync_ff <= nxt_ple_sync;
      j_sync_ff   <= nxt_j_sync;
      kn_sync_ff  <= nxt_kn_sync;
      clr_sync_ff <= nxt_clr_sync;
      pd_meta_ff  <= nxt_pd_meta;
      pd_sync_ff  <= nxt_pd_sync;
    end
  end

  // Register only advances while the snapshot FIFO has room; no state is lost
  assign step         = push_if.ready;
  assign step_stall_o = !push_if.ready;

  always_comb begin
    nxt_stage = stage_ff;
    if (step) begin
      if (!ple_s) begin
        nxt_stage = pd_sync_ff; // see (R02)
      end else begin
        nxt_stage = usr_shift_next(stage_ff, j_s, kn_s); // see (R03) see (R07)
      end
    end
    nxt_comp = ~nxt_stage[STAGES-1]; // see (R06)
  end

  // Clear acts without the clock and beats srst and every pin
  // Release is not synchronised; keep it away from rising clock edges
  always_ff @(posedge clock_i or negedge master_clear_n_i) begin
    if (!master_clear_n_i) begin
      stage_ff <= STAGE_RST; // see (R05)
      comp_ff  <= COMP_RST;
    end else if (srst_i) begin
      stage_ff <= STAGE_RST;
      comp_ff  <= COMP_RST;
    end else begin
      stage_ff <= nxt_stage; // see (R01)
      comp_ff  <= nxt_comp;
    end
  end

  // Outputs straight from flops, so they never glitch
  assign stage_out_o        = stage_ff; // see (R06)
  assign last_stage_out_n_o = comp_ff;

  // Every step pushes the new contents; held off while clear is seen
  assign push_if.valid = clr_idle_s;
  assign push_if.data  = nxt_stage;

  // Four words absorb short consumer pauses; longer ones stall the stages
  usr_fifo #(.WIDTH(STAGES), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .wr      (push_if),
    .rd      (pop_if)
  );

  assign snap_data_o  = pop_if.data;
  assign snap_valid_o = pop_if.valid;
  assign pop_if.ready = snap_ready_i;

  // Step and snapshot-word checks sit out srst and clear; the stages are forced then anyway
  sequence load_cmd_s;
    step && !ple_s;
  endsequence

  sequence shift_cmd_s;
    step && ple_s;
  endsequence

  sequence load_then_shift_s;
    load_cmd_s ##1 shift_cmd_s;
  endsequence

  sequence two_shifts_s;
    shift_cmd_s ##1 shift_cmd_s;
  endsequence

  sequence d_shift_s;
    step && ple_s && (j_s == kn_s);
  endsequence

  // Stall must freeze the stages, or a snapshot word would be lost
  property hold_p;
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      !step |=> $stable(stage_ff);
  endproperty

  stall_hold_a: assert property (hold_p) // see (R01)
    else $error("Stages changed while stalled");

  parallel_load_a: assert property ( // see (R02)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      load_cmd_s |=> stage_ff == $past(pd_sync_ff))
    else $error("Parallel load mismatch");

  right_shift_a: assert property ( // see (R03)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      shift_cmd_s |=> stage_ff[STAGES-1:1] == $past(stage_ff[STAGES-2:0]))
    else $error("Right shift mismatch");

  jk_entry_a: assert property ( // see (R07)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      shift_cmd_s |=> stage_ff[0] == ($past(stage_ff[0]) ? $past(kn_s) : $past(j_s)))
    else $error("First stage JK entry wrong");

  master_clear_a: assert property ( // see (R05)
    @(posedge clock_i) disable iff (srst_i)
      !master_clear_n_i |-> (stage_ff == STAGE_RST) && last_stage_out_n_o)
    else $error("Master clear did not empty stages");

  comp_output_a: assert property ( // see (R06)
    @(posedge clock_i) disable iff (srst_i)
      last_stage_out_n_o == !stage_out_o[STAGES-1])
    else $error("Inverted last stage wrong");

  load_shift_a: assert property ( // see (R03)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      load_then_shift_s |=> stage_ff[STAGES-1:1] == $past(pd_sync_ff[STAGES-2:0], 2))
    else $error("Shift after load lost data");

  double_shift_a: assert property ( // see (R03)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      two_shifts_s |=> stage_ff[STAGES-1:2] == $past(stage_ff[STAGES-3:0], 2))
    else $error("Two shifts did not move data two stages");

  d_entry_a: assert property ( // see (R07)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      d_shift_s |=> stage_ff[0] == $past(j_s))
    else $error("D-type serial entry wrong");

  load_comp_a: assert property ( // see (R06)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      load_cmd_s |=> last_stage_out_n_o == !$past(pd_sync_ff[STAGES-1]))
    else $error("Inverted output wrong after load");

  shift_comp_a: assert property ( // see (R06)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      shift_cmd_s |=> last_stage_out_n_o == !$past(stage_ff[STAGES-2]))
    else $error("Inverted output wrong after shift");

  sync_clear_a: assert property ( // see (R01)
    @(posedge clock_i) disable iff (!master_clear_n_i)
      srst_i |=> (stage_ff == STAGE_RST) && last_stage_out_n_o)
    else $error("Synchronous reset did not empty stages");

  snap_word_a: assert property ( // see (R06)
    @(posedge clock_i) disable iff (srst_i || !master_clear_n_i)
      push_if.valid && push_if.ready |=> stage_ff == $past(push_if.data))
    else $error("Snapshot word differs from stages");

  snap_valid_a: assert property ( // see (R06)
    @(posedge clock_i) disable iff (srst_i)
      push_if.valid && push_if.ready |=> snap_valid_o)
    else $error("Pushed word not offered");

  drain_step_a: assert property ( // see (R01)
    @(posedge clock_i) disable iff (srst_i)
      step_stall_o && snap_ready_i |=> !step_stall_o)
    else $error("Stall outlived a pop");
endmodule : usr_shift_reg

// *** hw/usr_pkg.sv ***
package usr_pkg;
  localparam int unsigned STAGES      = 4;
  localparam int unsigned FIFO_DEPTH  = 4;
  localparam int unsigned PTR_W       = 2;
  localparam int unsigned CNT_W       = 3;
  localparam logic [3:0]  STAGE_RST   = 4'h0;
  localparam logic        COMP_RST    = 1'h1;
  localparam logic [1:0]  SYNC_RST    = 2'h0;
  localparam logic [1:0]  SYNC_HI_RST = 2'h3;

  typedef logic [STAGES-1:0] usr_word_t;

  // Right shift; first stage is a JK flip-flop with K inverted
  function automatic usr_word_t usr_shift_next(input usr_word_t cur,
                                               input logic      j,
                                               input logic      k_n);
    logic first;
    first = cur[0] ? k_n : j;
    return {cur[STAGES-2:0], first};
  endfunction : usr_shift_next
endpackage : usr_pkg

// *** hw/usr_stream_if.sv ***
`timescale 1ns/1ps
interface usr_stream_if #(parameter int unsigned WIDTH = 4);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : usr_stream_if

// *** hw/usr_fifo.sv ***
`timescale 1ns/1ps
module usr_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  usr_stream_if.snk wr,
  usr_stream_if.src rd
);
  import usr_pkg::*;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [PTR_W-1:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             push, pop;

  assign wr.ready = (cnt_ff != CNT_W'(DEPTH));
  assign rd.valid = (cnt_ff != '0);
  assign rd.data  = mem_ff[rptr_ff];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    nxt_mem  = mem_ff;
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_cnt  = cnt_ff;
    if (push) begin
      nxt_mem[wptr_ff] = wr.data;
      nxt_wptr         = wptr_ff + PTR_W'(1);
    end
    if (pop) begin
      nxt_rptr = rptr_ff + PTR_W'(1);
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    mem_ff <= nxt_mem;
    if (srst_i) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff  <= nxt_cnt;
    end
  end
endmodule : usr_fifo

// *** dv/usr_partner.sv ***
`timescale 1ns/1ps
module usr_partner (
  input  wire logic d_mode_i,
  input  wire logic ser_i,
  input  wire logic ser_k_n_i,
  input  wire logic hold_i,
  output logic      j_o,
  output logic      k_n_o,
  output logic      ready_o
);
  assign j_o     = ser_i;
  // D entry ties both serial inputs together
  assign k_n_o   = d_mode_i ? ser_i : ser_k_n_i;
  assign ready_o = ~hold_i;
endmodule : usr_partner

// *** dv/tb_usr_shift_reg.sv ***
`timescale 1ns/1ps
module tb_usr_shift_reg;
  import usr_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic       j;
    logic       k;
    logic [2:0] n;
    logic [3:0] e;
  } usr_row_s;
  logic       clock_i = 1'b0;
  logic       srst_i  = 1'b1;
  logic       clr_n   = 1'b1;
  logic       ld_n    = 1'b1;
  logic       dm      = 1'b1;
  logic       ser     = 1'b0;
  logic       serk    = 1'b0;
  logic       hold    = 1'b0;
  logic [3:0] pd      = 4'h0;
  logic       j;
  logic       k_n;
  logic       rdy;
  logic       stall;
  logic       sv;
  logic       qn;
  logic [3:0] q;
  logic [3:0] exp;
  logic [3:0] held;
  logic [3:0] sd;
  int         error_cnt = 0;
  int         cmp_count = 0;
  // Load, J, K_n, shift count, expected stages; D, toggle and hold entry
  usr_row_s rows [5] = '{'{4'h5, 1'b1, 1'b1, 3'h2, 4'h7}, '{4'ha, 1'b0, 1'b0, 3'h3, 4'h0},
                         '{4'h3, 1'b1, 1'b0, 3'h4, 4'h5}, '{4'hd, 1'b0, 1'b1, 3'h3, 4'hf},
                         '{4'hf, 1'b0, 1'b0, 3'h4, 4'h0}};

  usr_partner i_far (.d_mode_i(dm), .ser_i(ser), .ser_k_n_i(serk), .hold_i(hold),
                     .j_o(j), .k_n_o(k_n), .ready_o(rdy));
  usr_shift_reg i_dut (.clock_i(clock_i), .srst_i(srst_i), .master_clear_n_i(clr_n),
                       .parallel_load_enable_n_i(ld_n), .parallel_data_in_i(pd),
                       .j_i(j), .k_n_i(k_n), .stage_out_o(q), .last_stage_out_n_o(qn),
                       .step_stall_o(stall), .snap_data_o(sd), .snap_valid_o(sv),
                       .snap_ready_i(rdy));

  task automatic chk(input string nm, input logic [3:0] s, input logic [3:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task summarize;
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial forever #50 clock_i = ~clock_i;

  // Whole run is under 150 cycles
  initial begin
    #50us;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
    chk("stage", q, STAGE_RST);
    chk("comp", {3'h0, qn}, 4'h1);
    chk("valid", {3'h0, sv}, 4'h0);
    chk("stall", {3'h0, stall}, 4'h0);
    foreach (rows[i]) begin
      ld_n = 1'b0;
      pd   = rows[i].a;
      repeat (4) @(negedge clock_i);
      chk("load", q, pd);
      chk("snap", sd, pd);
      ld_n = 1'b1;
      ser  = rows[i].j;
      serk = rows[i].k;
      dm   = (rows[i].j == rows[i].k);
      exp  = rows[i].e;
      // Two edges of pin latency still load, then one shift per edge
      repeat (rows[i].n + 2) @(negedge clock_i);
      chk("shift", q, exp);
      chk("comp", {3'h0, qn}, {3'h0, ~exp[3]});
      chk("snap", sd, exp);
    end
    // A single one enters on the last step before the FIFO fills, so a missed stall shows
    hold = 1'b1;
    ser  = 1'b1;
    repeat (6) @(negedge clock_i);
    held = q;
    chk("stall", {3'h0, stall}, 4'h1);
    @(negedge clock_i);
    chk("hold", q, held);
    chk("hold", q, 4'h1);
    chk("valid", {3'h0, sv}, 4'h1);
    hold = 1'b0;
    ld_n = 1'b0;
    pd   = 4'hf;
    repeat (6) @(negedge clock_i);
    chk("stall", {3'h0, stall}, 4'h0);
    chk("load", q, 4'hf);
    // Clear lands between edges, with a load still pending
    clr_n = 1'b0;
    #1;
    chk("clear", q, 4'h0);
    chk("comp", {3'h0, qn}, 4'h1);
    @(negedge clock_i);
    chk("clear", q, 4'h0);
    clr_n = 1'b1;
    @(negedge clock_i);
    chk("resume", q, 4'hf);
    // Second synchronous reset mid-run, pins left standing
    srst_i = 1'b1;
    @(negedge clock_i);
    chk("srst", q, STAGE_RST);
    chk("srst comp", {3'h0, qn}, 4'h1);
    chk("srst valid", {3'h0, sv}, 4'h0);
    srst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk("sync flush", q, STAGE_RST);
    @(negedge clock_i);
    chk("reload", q, 4'hf);
    summarize();
  end
endmodule : tb_usr_shift_reg
